// file: logic/ovs_pkg.sv
/*
 Shared constants, types and mode decode for the oversampling average block.
 Assumes a single 125 MHz clock domain.
*/
package ovs_pkg;
   localparam int NCH = 4;
   localparam int SW = 14;
   localparam int FD = 8;
   localparam int CLK_NS = 8;
   localparam int SAMPLE_NS = 250;
   localparam logic [5:0] GAP_CYC = 6'((SAMPLE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [2:0] RATIO_RST = 3'h0;
   localparam logic [7:0] STATUS_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CONV = 2'h1,
      ST_GAP = 2'h2,
      ST_POST = 2'h3
   } ovs_state_e;

   // Log2 of the sample count; zero when averaging is off or the code is invalid
   function automatic logic [2:0] ovs_log2n(input logic style, input logic [2:0] code);
      logic ok;
      ok = style ? (code[2] == 1'b0 && code != 3'h0) : (code != 3'h0 && code <= 3'h5);
      return ok ? code : 3'h0;
   endfunction
endpackage

// file: logic/ovs_link_if.sv
/*
 Interface between the averaging core, its history store and its alert unit.
 Assumes all three parties share one clock.
*/
`timescale 1ns/1ps
interface ovs_link_if;
   logic push;
   logic fill;
   logic [3:0][13:0] smp;
   logic [3:0][2:0][16:0] sums;
   logic chk;
   logic [3:0][15:0] avg;
   logic [15:0] hi_thr;
   logic [15:0] lo_thr;
   logic clr_rd;
   logic clr_sw;
   logic clr_pin;
   logic [7:0] status;
   logic flag;
   modport core (output push, fill, smp, chk, avg, hi_thr, lo_thr, clr_rd, clr_sw,
      clr_pin, input sums, status, flag);
   modport hist (input push, fill, smp, output sums);
   modport alrt (input chk, avg, hi_thr, lo_thr, clr_rd, clr_sw, clr_pin,
      output status, flag);
endinterface

// file: logic/ovs_history.sv
/*
 Eight-deep per-channel history of conversion results with running sums.
 Assumes push is a one-cycle pulse per completed conversion.
*/
`timescale 1ns/1ps
module ovs_history (
   input wire logic clk,   // System clock
   input wire logic reset, // Synchronous reset
   ovs_link_if.hist lk     // History port
);
   typedef struct packed {
      logic [3:0][7:0][13:0] mem;
   } ovs_hist_s;

   ovs_hist_s s_q;
   ovs_hist_s s_d;

   // ----------------------------------------
   // Shift or fill
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      if (lk.push) begin
         for (int ch = 0; ch < ovs_pkg::NCH; ch++) begin
            for (int e = 0; e < ovs_pkg::FD; e++) begin
               if (lk.fill || e == 0) begin
                  s_d.mem[ch][e] = lk.smp[ch];
               end else begin
                  s_d.mem[ch][e] = s_q.mem[ch][e-1];
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Sums of the newest 2, 4 and 8 entries
   // ----------------------------------------
   for (genvar ch = 0; ch < ovs_pkg::NCH; ch++) begin : g_sum
      assign lk.sums[ch][0] = 17'($signed(s_q.mem[ch][0])) + 17'($signed(s_q.mem[ch][1]));
      assign lk.sums[ch][1] = lk.sums[ch][0] + 17'($signed(s_q.mem[ch][2]))
         + 17'($signed(s_q.mem[ch][3]));
      assign lk.sums[ch][2] = lk.sums[ch][1] + 17'($signed(s_q.mem[ch][4]))
         + 17'($signed(s_q.mem[ch][5])) + 17'($signed(s_q.mem[ch][6]))
         + 17'($signed(s_q.mem[ch][7]));
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_fifo_shift: assert property (lk.push && !lk.fill |=>
      s_q.mem[0][7] == $past(s_q.mem[0][6]) && s_q.mem[0][0] == $past(lk.smp[0]))
      else $error("history did not shift");
   a_fifo_fill: assert property (lk.push && lk.fill |=>
      s_q.mem[3][7] == $past(lk.smp[3]) && s_q.mem[3][0] == $past(lk.smp[3]))
      else $error("history not filled");
endmodule

// file: logic/ovs_alert.sv
/*
 Out-of-range comparator with sticky per-channel status and a shared flag.
 Assumes chk pulses for one cycle when avg holds a fresh result.
*/
`timescale 1ns/1ps
module ovs_alert (
   input wire logic clk,   // System clock
   input wire logic reset, // Synchronous reset
   ovs_link_if.alrt lk     // Alert port
);
   typedef struct packed {
      logic [7:0] status;
      logic pin;
   } ovs_alert_s;

   ovs_alert_s s_q;
   ovs_alert_s s_d;
   logic [7:0] hit;

   // ----------------------------------------
   // Compare, high bit even, low bit odd
   // ----------------------------------------
   for (genvar ch = 0; ch < ovs_pkg::NCH; ch++) begin : g_cmp
      assign hit[2*ch] = $signed(lk.avg[ch]) > $signed(lk.hi_thr);
      assign hit[2*ch+1] = $signed(lk.avg[ch]) < $signed(lk.lo_thr);
   end

   always_comb begin
      s_d = s_q;
      if (lk.clr_sw) begin
         s_d.status = ovs_pkg::STATUS_RST;
         s_d.pin = 1'b0;
      end else begin
         // New hits win over a clear in the same cycle
         s_d.status = (s_q.status & ~{8{lk.clr_rd}}) | (lk.chk ? hit : 8'h00);
         s_d.pin = (s_q.pin & ~lk.clr_pin) | (lk.chk & (|hit));
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lk.status = s_q.status;
   assign lk.flag = s_q.pin;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_status_high: assert property (lk.chk && !lk.clr_sw && $signed(lk.avg[1]) >
      $signed(lk.hi_thr) |=> lk.status[2]) else $error("high hit lost");
   a_status_read: assert property (lk.clr_rd && !lk.chk |=> lk.status == 8'h00)
      else $error("status not cleared by read");
   a_pin_clear: assert property (lk.clr_pin && !lk.chk |=> !lk.flag)
      else $error("flag not cleared by chip select");
endmodule

// file: logic/ovs_average.sv
/*
 Oversampling averager: block and rolling averaging, resolution boost and
 out-of-range flag for a four-channel converter.
 Assumes cs_fall and conv_done are one-cycle pulses synchronous to clk, and
 that the converter answers every conv_start with exactly one conv_done.
*/
`timescale 1ns/1ps
module ovs_average (
   input wire logic clk,                          // 125 MHz clock
   input wire logic reset,                        // Synchronous reset, high
   input wire logic cs_fall,                      // Chip-select falling edge pulse
   input wire logic conv_done,                    // Conversion complete pulse
   input wire logic [3:0][13:0] conv_data,        // Raw signed samples
   input wire logic averaging_style_select,       // 0 block, 1 rolling
   input wire logic [2:0] average_ratio_field,    // Ratio code
   input wire logic extra_precision_bit,          // Resolution boost
   input wire logic reference_source_select,      // Reference select
   input wire logic [1:0] output_lane_count_field, // Serial lane mode
   input wire logic alert_output_enable,          // Flag pin enable
   input wire logic [15:0] alert_high_thr,        // Signed high limit
   input wire logic [15:0] alert_low_thr,         // Signed low limit
   input wire logic soft_reset,                   // Software reset pulse
   input wire logic status_read,                  // Status read pulse
   output logic conv_start,                       // Start one conversion
   output logic [3:0][15:0] result,               // Signed results
   output logic result_wide,                      // Result carries 16 bits
   output logic result_ready,                     // New result pulse
   output logic busy,                             // Sequence in progress
   output logic [7:0] alert_status,               // Sticky alert bits
   output logic lane_d_or_flag_pin,               // Flag pin level
   output logic lane_d_or_flag_pin_oe             // Flag pin drive enable
);
   typedef struct packed {
      ovs_pkg::ovs_state_e st;
      logic [5:0] gap;
      logic [5:0] cnt;
      logic [3:0][18:0] acc;
      logic [2:0] k;
      logic blk;
      logic roll;
      logic [3:0][15:0] avg;
      logic wide;
      logic ready;
      logic chk;
      logic start;
      logic [2:0] ratio_p1;
      logic [2:0] ratio_eff;
      logic ref_q;
      logic fill_pend;
   } ovs_core_s;

   ovs_core_s s_q;
   ovs_core_s s_d;
   ovs_link_if lk ();
   logic push;
   logic [2:0] k_new;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   ovs_history u_hist (
      .clk(clk),
      .reset(reset),
      .lk(lk.hist)
   );

   ovs_alert u_alert (
      .clk(clk),
      .reset(reset),
      .lk(lk.alrt)
   );

   assign push = (s_q.st == ovs_pkg::ST_CONV) && conv_done && !soft_reset;
   assign k_new = ovs_pkg::ovs_log2n(averaging_style_select, s_q.ratio_eff);

   assign lk.push = push;
   assign lk.fill = s_q.fill_pend;
   assign lk.smp = conv_data;
   assign lk.chk = s_q.chk;
   assign lk.avg = s_q.avg;
   assign lk.hi_thr = alert_high_thr;
   assign lk.lo_thr = alert_low_thr;
   assign lk.clr_rd = status_read;
   assign lk.clr_sw = soft_reset;
   assign lk.clr_pin = cs_fall;

   // ----------------------------------------
   // Sequencer and averaging
   // ----------------------------------------
   always_comb begin
      logic signed [18:0] sm;
      logic signed [20:0] w;
      sm = '0;
      w = '0;
      s_d = s_q;
      s_d.start = 1'b0;
      s_d.ready = 1'b0;
      s_d.chk = 1'b0;
      s_d.ref_q = reference_source_select;
      if (s_q.gap != ovs_pkg::GAP_CYC) begin
         s_d.gap = s_q.gap + 6'h1;
      end
      unique case (s_q.st)
         ovs_pkg::ST_IDLE: begin
            if (cs_fall) begin
               s_d.start = 1'b1;
               s_d.gap = 6'h1;
               s_d.cnt = 6'h0;
               s_d.acc = '0;
               s_d.k = k_new;
               s_d.blk = !averaging_style_select && k_new != 3'h0;
               s_d.roll = averaging_style_select && k_new != 3'h0;
               s_d.st = ovs_pkg::ST_CONV;
            end
         end
         ovs_pkg::ST_CONV: begin
            if (conv_done) begin
               for (int ch = 0; ch < ovs_pkg::NCH; ch++) begin
                  s_d.acc[ch] = 19'($signed(s_q.acc[ch]) + $signed(conv_data[ch]));
               end
               s_d.cnt = s_q.cnt + 6'h1;
               if (s_q.blk && (s_q.cnt + 6'h1) < (6'h1 << s_q.k)) begin
                  s_d.st = ovs_pkg::ST_GAP;
               end else begin
                  s_d.st = ovs_pkg::ST_POST;
               end
            end
         end
         ovs_pkg::ST_GAP: begin
            if (s_q.gap == ovs_pkg::GAP_CYC) begin
               s_d.start = 1'b1;
               s_d.gap = 6'h1;
               s_d.st = ovs_pkg::ST_CONV;
            end
         end
         ovs_pkg::ST_POST: begin
            for (int ch = 0; ch < ovs_pkg::NCH; ch++) begin
               if (s_q.roll) begin
                  sm = 19'($signed(lk.sums[ch][s_q.k - 3'h1]));
               end else begin
                  sm = $signed(s_q.acc[ch]);
               end
               w = (21'(sm) <<< 2) >>> s_q.k;
               if (s_q.k != 3'h0 && (s_q.roll || extra_precision_bit)) begin
                  s_d.avg[ch] = w[15:0];
               end else begin
                  s_d.avg[ch] = {{2{w[15]}}, w[15:2]};
               end
            end
            s_d.wide = s_q.k != 3'h0 && (s_q.roll || extra_precision_bit);
            s_d.ready = 1'b1;
            s_d.chk = 1'b1;
            s_d.acc = '0;
            s_d.ratio_p1 = average_ratio_field;
            s_d.ratio_eff = s_q.ratio_p1;
            s_d.st = ovs_pkg::ST_IDLE;
         end
      endcase
      // Set requests win over the clear taken by the filling conversion
      s_d.fill_pend = (s_q.fill_pend && !push) || soft_reset
         || (reference_source_select != s_q.ref_q);
      if (soft_reset) begin
         s_d.st = ovs_pkg::ST_IDLE;
         s_d.start = 1'b0;
         s_d.ready = 1'b0;
         s_d.chk = 1'b0;
         s_d.acc = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.st <= ovs_pkg::ST_IDLE;
         s_q.gap <= ovs_pkg::GAP_CYC;
         s_q.ratio_p1 <= ovs_pkg::RATIO_RST;
         s_q.ratio_eff <= ovs_pkg::RATIO_RST;
         s_q.fill_pend <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign conv_start = s_q.start;
   assign result = s_q.avg;
   assign result_wide = s_q.wide;
   assign result_ready = s_q.ready;
   assign busy = s_q.st != ovs_pkg::ST_IDLE;
   assign alert_status = lk.status;
   assign lane_d_or_flag_pin_oe = output_lane_count_field != 2'h0 && alert_output_enable;
   assign lane_d_or_flag_pin = lk.flag && lane_d_or_flag_pin_oe;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || soft_reset);

   sequence s_conv_end;
      s_q.st == ovs_pkg::ST_CONV && conv_done;
   endsequence
   sequence s_post_then_ready;
      s_q.st == ovs_pkg::ST_POST ##1 result_ready;
   endsequence

   a_gap_spacing: assert property (s_q.st == ovs_pkg::ST_GAP && s_q.gap < ovs_pkg::GAP_CYC
      |=> !conv_start) else $error("next sample started too early");
   a_block_count: assert property (s_conv_end ##0 s_q.blk
      && (s_q.cnt + 6'h1) < (6'h1 << s_q.k) |=> s_q.st == ovs_pkg::ST_GAP)
      else $error("block sequence ended early");
   a_roll_result: assert property (s_conv_end ##0 !s_q.blk |=> s_post_then_ready)
      else $error("no result after conversion");
   a_width_flag: assert property (result_ready && s_q.roll |-> result_wide)
      else $error("rolling result not wide");
   a_fill_drop: assert property (push && reference_source_select == s_q.ref_q
      |=> !s_q.fill_pend) else $error("fill request not cleared");
   a_ratio_lag: assert property (s_q.st == ovs_pkg::ST_POST |=>
      s_q.ratio_eff == $past(s_q.ratio_p1)) else $error("ratio pipeline skipped");

   // ----------------------------------------
   // Request sequencing
   // ----------------------------------------
   sequence s_idle_request;
      s_q.st == ovs_pkg::ST_IDLE && cs_fall;
   endsequence
   sequence s_last_sample;
      s_conv_end ##0 (s_q.blk && (s_q.cnt + 6'h1) == (6'h1 << s_q.k));
   endsequence

   a_start_taken: assert property (
      s_idle_request |=> conv_start && busy)
      else $error("request not started");
   a_start_single: assert property (
      conv_start |=> !conv_start)
      else $error("start pulse too long");
   a_no_restart: assert property (
      s_q.st == ovs_pkg::ST_CONV |=> !conv_start)
      else $error("start while converting");
   a_busy_refused: assert property (
      busy && cs_fall && s_q.st != ovs_pkg::ST_GAP |=> !conv_start)
      else $error("request taken while busy");
   a_gap_reach: assert property (
      s_q.st == ovs_pkg::ST_GAP |-> ##[1:32] conv_start)
      else $error("next sample never started");
   a_block_last: assert property (
      s_last_sample |=> s_q.st == ovs_pkg::ST_POST)
      else $error("block sequence overran");
   a_roll_one: assert property (
      s_conv_end ##0 s_q.roll |=> s_q.st == ovs_pkg::ST_POST)
      else $error("rolling took extra samples");
   a_push_each: assert property (
      s_conv_end |-> push)
      else $error("conversion missed history");

   // ----------------------------------------
   // Result timing and scaling
   // ----------------------------------------
   a_ready_single: assert property (
      result_ready |=> !result_ready)
      else $error("ready pulse too long");
   a_ready_idle: assert property (
      result_ready |-> !busy)
      else $error("ready while busy");
   a_acc_dropped: assert property (
      result_ready |-> s_q.acc == '0)
      else $error("block samples kept");
   a_narrow_sign: assert property (
      result_ready && !result_wide |-> result[2][15:14] == {2{result[2][13]}})
      else $error("narrow result not extended");
   a_block_width: assert property (
      result_ready && s_q.blk |-> result_wide == $past(extra_precision_bit))
      else $error("block result width wrong");
   a_plain_width: assert property (
      result_ready && !s_q.blk && !s_q.roll |-> !result_wide)
      else $error("plain result widened");
   a_result_hold: assert property (
      $changed(result) |-> result_ready)
      else $error("result changed without ready");

   // ----------------------------------------
   // Ratio, mode decode and history
   // ----------------------------------------
   a_ratio_take: assert property (
      s_q.st == ovs_pkg::ST_POST |=> s_q.ratio_p1 == $past(average_ratio_field))
      else $error("ratio not taken at result");
   a_ratio_keep: assert property (
      s_q.st != ovs_pkg::ST_POST |=> $stable(s_q.ratio_eff))
      else $error("ratio changed between results");
   a_block_code: assert property (
      s_idle_request ##0 (!averaging_style_select && s_q.ratio_eff > 3'h5) |=> !s_q.blk)
      else $error("invalid block code used");
   a_roll_code: assert property (
      s_idle_request ##0 (averaging_style_select && s_q.ratio_eff[2]) |=> !s_q.roll)
      else $error("invalid rolling code used");
   a_block_range: assert property (
      s_q.blk |-> s_q.k >= 3'h1 && s_q.k <= 3'h5)
      else $error("block ratio out of range");
   a_roll_range: assert property (
      s_q.roll |-> s_q.k >= 3'h1 && s_q.k <= 3'h3)
      else $error("rolling ratio out of range");
   a_mode_single: assert property (
      !(s_q.blk && s_q.roll))
      else $error("both averaging styles active");
   a_fill_arm: assert property (
      $changed(reference_source_select) |=> s_q.fill_pend)
      else $error("reference toggle did not arm fill");

   // ----------------------------------------
   // Alert flag and status
   // ----------------------------------------
   a_oe_gate: assert property (
      !lane_d_or_flag_pin_oe |-> !lane_d_or_flag_pin)
      else $error("flag driven while disabled");
   a_flag_shown: assert property (
      lane_d_or_flag_pin_oe |-> lane_d_or_flag_pin == lk.flag)
      else $error("flag pin differs from alert");
   a_status_keep: assert property (
      !lk.chk && !status_read |=> $stable(alert_status))
      else $error("status changed without event");
   a_high_seen: assert property (
      lk.chk && $signed(result[0]) > $signed(alert_high_thr) |=> lk.flag && alert_status[0])
      else $error("high crossing not flagged");
   a_low_seen: assert property (
      lk.chk && $signed(result[3]) < $signed(alert_low_thr) |=> alert_status[7])
      else $error("low crossing not flagged");
   a_flag_keep: assert property (
      !lk.chk && !cs_fall |=> $stable(lk.flag))
      else $error("flag changed without event");
endmodule

// file: test/ovs_conv_model.sv
/*
 Converter model: answers each conv_start with one conv_done after lat cycles.
 Assumes lat is at least 1 and samp is stable when conv_start is seen.
*/
`timescale 1ns/1ps
module ovs_conv_model (
   input wire logic clk,                // System clock
   input wire logic reset,              // Synchronous reset
   input wire logic conv_start,         // Start request
   input wire logic [5:0] lat,          // Answer delay in cycles
   input wire logic [3:0][13:0] samp,   // Sample set to return
   output logic conv_done,              // Result pulse
   output logic [3:0][13:0] conv_data   // Result, junk outside the pulse
);
   logic [5:0] cnt_q;
   logic [3:0][13:0] hold_q;
   always_ff @(posedge clk) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (reset) begin
         cnt_q <= 6'h00;
         conv_data <= '0;
      end else if (conv_start) begin
         cnt_q <= lat;
         hold_q <= samp;
      end else if (cnt_q != 6'h00) begin
         cnt_q <= cnt_q - 6'h01;
         if (cnt_q == 6'h01) begin
            conv_done <= 1'b1;
            conv_data <= hold_q;
         end
      end
   end
endmodule

// file: test/ovs_average_test.sv
/*
 Self-checking bench for the oversampling averager.
 Assumes the converter model ovs_conv_model and one 125 MHz clock.
*/
`timescale 1ns/1ps
module ovs_average_test;
   logic clk = 1'b0, reset = 1'b1, cs_fall = 1'b0, style = 1'b0, ext = 1'b0;
   logic ref_sel = 1'b0, aen = 1'b0, soft_reset = 1'b0, status_read = 1'b0;
   logic conv_start, conv_done, result_wide, result_ready, busy, pin, oe, fill, flag;
   logic [1:0] lanes = 2'h0;
   logic [2:0] ratio = 3'h0, r1, r2;
   logic [5:0] lat = 6'h01;
   logic [15:0] hi = 16'h0000, lo = 16'h0000;
   logic [7:0] alert_status, sts;
   logic [3:0][13:0] conv_data, samp = '0;
   logic [3:0][15:0] result;
   logic [31:0] seed = 32'h00000026;
   int n_mismatch = 0, cmp_count = 0, ncv;
   int acc[4], hist[4][8];

   ovs_average i_ovs_average (.clk(clk), .reset(reset), .cs_fall(cs_fall),
      .conv_done(conv_done), .conv_data(conv_data), .averaging_style_select(style),
      .average_ratio_field(ratio), .extra_precision_bit(ext),
      .reference_source_select(ref_sel), .output_lane_count_field(lanes),
      .alert_output_enable(aen), .alert_high_thr(hi), .alert_low_thr(lo),
      .soft_reset(soft_reset), .status_read(status_read), .conv_start(conv_start),
      .result(result), .result_wide(result_wide), .result_ready(result_ready),
      .busy(busy), .alert_status(alert_status), .lane_d_or_flag_pin(pin),
      .lane_d_or_flag_pin_oe(oe));

   ovs_conv_model i_ovs_conv_model (.clk(clk), .reset(reset), .conv_start(conv_start),
      .lat(lat), .samp(samp), .conv_done(conv_done), .conv_data(conv_data));

   // ----------------------------------------
   // Reference model of history and ratio
   // ----------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         r1 = 3'h0;
         r2 = 3'h0;
         fill = 1'b1;
      end
      if (conv_done === 1'b1) begin
         ncv++;
         for (int c = 0; c < 4; c++) begin
            acc[c] += $signed(conv_data[c]);
            for (int j = 7; j > 0; j--)
               hist[c][j] = fill ? $signed(conv_data[c]) : hist[c][j-1];
            hist[c][0] = $signed(conv_data[c]);
         end
         fill = 1'b0;
      end
      if (result_ready === 1'b1) begin
         r2 = r1;
         r1 = ratio;
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int lg(input logic st, input logic [2:0] code);
      if (st ? (!code[2] && code != 3'h0) : (code != 3'h0 && code <= 3'h5))
         return code;
      return 0;
   endfunction

   function automatic logic [15:0] exp_avg(input int c, input logic st, input int k);
      int s;
      s = 0;
      if (k == 0)
         return 16'(hist[c][0]);
      if (!st)
         return ext ? 16'((acc[c] * 4) >>> k) : 16'(acc[c] >>> k);
      for (int j = 0; j < (1 << k); j++)
         s += hist[c][j];
      return 16'((s * 4) >>> k);
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------
   // Transactions
   // ----------------------------------------
   task automatic do_conv(input logic dbl);
      int k, w;
      logic [7:0] bits;
      logic [15:0] e;
      @(negedge clk);
      k = lg(style, r2);
      cs_fall = 1'b1;
      flag = 1'b0;
      ncv = 0;
      acc = '{default: 0};
      @(negedge clk);
      cs_fall = 1'b0;
      if (dbl) begin
         repeat (3) @(negedge clk);
         cs_fall = 1'b1; // Ignored while busy, still clears the pin
         flag = 1'b0;
         @(negedge clk);
         cs_fall = 1'b0;
      end
      w = 0;
      while (result_ready !== 1'b1 && w < 4000) begin
         for (int c = 0; c < 4; c++)
            samp[c] = 14'(rnd());
         @(negedge clk);
         w++;
      end
      chk(16'(w < 4000), 16'h0001);
      chk(16'(ncv), (k != 0 && !style) ? 16'(1 << k) : 16'h0001);
      chk(16'(busy), 16'h0000);
      chk(16'(result_wide), 16'(k != 0 && (style || ext)));
      bits = 8'h00;
      for (int c = 0; c < 4; c++) begin
         e = exp_avg(c, style, k);
         chk(result[c], e);
         bits[2*c] = $signed(e) > $signed(hi);
         bits[2*c+1] = $signed(e) < $signed(lo);
      end
      sts |= bits;
      flag |= |bits;
      @(negedge clk);
      chk(16'(alert_status), 16'(sts));
      chk(16'(pin), 16'(flag && lanes != 2'h0 && aen));
      chk(16'(oe), 16'(lanes != 2'h0 && aen));
   endtask

   task automatic pulse_ctl(input logic rd);
      @(negedge clk);
      if (rd)
         status_read = 1'b1;
      else
         soft_reset = 1'b1;
      sts = 8'h00;
      if (!rd) begin
         flag = 1'b0;
         fill = 1'b1;
      end
      @(negedge clk);
      status_read = 1'b0;
      soft_reset = 1'b0;
      chk(16'(alert_status), 16'h0000);
      chk(16'(pin), 16'(flag && lanes != 2'h0 && aen));
   endtask

   initial begin
      forever #4 clk = ~clk;
   end

   initial begin
      #720000;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      sts = 8'h00;
      flag = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 64; i++) begin
         ratio = i < 32 ? 3'(i) : 3'(rnd());
         style = i < 32 ? i[3] : 1'(rnd());
         ext = 1'(rnd());
         lanes = 2'(rnd());
         aen = 1'(rnd());
         lat = 6'(1 + rnd() % 36);
         hi = 16'(int'(rnd() % 16000) - 8000);
         lo = hi - 16'(1 + rnd() % 12000);
         if (i % 9 == 4)
            pulse_ctl(1'b0);
         if (i % 5 == 2)
            pulse_ctl(1'b1);
         if (i % 13 == 6) begin
            ref_sel = ~ref_sel;
            fill = 1'b1;
         end
         do_conv(lat > 6'h07 && i % 3 == 0);
      end
      print_verdict();
   end
endmodule
